// [design/halt_reason_encoder.sv]
`timescale 1ns/10ps
module halt_reason_encoder
    import halt_reason_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ext_halt_t ext_halt,
    input wire cpu_events_t events,
    input wire logic [31:0] status_word,
    input wire logic restart_done,
    input wire logic powerup_restart,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic [31:0] saved_status_register,
    output logic [CODE_W-1:0] restart_code,
    output logic halted,
    output logic report_message,
    output logic irq
);
    localparam logic [7:0] A_SAVED = SAVED_IPR_NUM;
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CLEAR = 8'h04;
    localparam logic [7:0] A_ENABLE = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0C;

    halt_state_t state;
    halt_state_t next_state;
    logic [1:0] ev_status;
    logic [1:0] ev_enable;
    logic [31:0] wd_pc;

    wire logic interrupt_stack_flag = status_word[IS_FLAG_BIT];
    wire logic [2:0] mode = events.mode;
    wire logic ext_req = ext_halt.console_break | ext_halt.bus_halt_line
                       | (ext_halt.aux_halt & ext_halt.aux_halt_enable);
    wire logic ill_mode = (mode == 3'h5) | (mode == 3'h6) | (mode == 3'h7);
    wire logic [1:0] mode_off = mode[1:0] - 2'h1;

    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC*CODE_W-1:0] codes;
    assign req[0] = events.selftest_fail;
    assign req[1] = events.mchk & events.mchk_servicing;
    assign req[2] = events.mchk & events.ksnv_servicing;
    assign req[3] = events.mchk & events.mchk_reporting;
    assign req[4] = events.access_fault & events.mchk_servicing;
    assign req[5] = events.access_fault & events.ksnv_servicing;
    assign req[6] = events.vec_read_err;
    assign req[7] = events.vec_valid & (events.vec_low == VEC_LOW_3);
    assign req[8] = events.vec_valid & (events.vec_low == VEC_LOW_2);
    assign req[9] = events.chm_exec & interrupt_stack_flag;
    assign req[10] = events.chm_exec & events.chm_vec_bit0;
    assign req[11] = events.isp_push_fault;
    assign req[12] = events.exc_start & ill_mode & (mode_off == 2'h0);
    assign req[13] = events.exc_start & ill_mode & (mode_off == 2'h1);
    assign req[14] = events.exc_start & ill_mode & (mode_off == 2'h2);
    assign req[15] = events.rei_start & ill_mode & (mode_off == 2'h0);
    assign req[16] = events.rei_start & ill_mode & (mode_off == 2'h1);
    assign req[17] = events.rei_start & ill_mode & (mode_off == 2'h2);
    assign req[18] = (events.halt_inst & events.kernel_mode) | ext_req;

    assign codes = {ext_req & ~(events.halt_inst & events.kernel_mode) ? C_EXT : C_HLT,
                    C_REI7, C_REI6, C_REI5, C_EXC7, C_EXC6, C_EXC5,
                    C_ISP, C_CHM_VEC, C_CHM_IS, C_VEC2, C_VEC3, C_VEC_RD,
                    C_KSP_AV, C_MCHK_AV, C_DBL, C_DBL3, C_DBL2, C_SELFTEST};

    logic [CODE_W-1:0] hit_code;
    logic hit;
    halt_priority #(.N(NUM_SRC)) u_pri (
        .req(req),
        .codes(codes),
        .code(hit_code),
        .any(hit)
    );

    // State walk
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (hit || powerup_restart) begin
                    next_state = ST_SAVE;
                end
            end
            ST_SAVE: next_state = ST_HALTED;
            ST_HALTED: begin
                if (restart_done) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    wire logic capture = (state == ST_RUN) && (hit || powerup_restart);
    wire logic [CODE_W-1:0] cap_code = powerup_restart ? C_PWRUP : hit_code;
    wire logic [1:0] ev_set = {capture & ~powerup_restart, capture & powerup_restart};
    wire logic [1:0] ev_clr = (wr && addr == A_CLEAR) ? wdata[1:0] : 2'h0;
    wire logic [31:0] next_saved = {status_word[31:SAVED_CODE_MSB+1], cap_code,
                                    status_word[SAVED_CODE_LSB-1:0]};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_RUN;
            saved_status_register <= SAVED_RESET;
            restart_code <= C_NONE;
            halted <= 1'b0;
            report_message <= 1'b0;
            ev_status <= 2'h0;
            ev_enable <= 2'h0;
            irq <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            if (capture) begin
                saved_status_register <= next_saved;
                restart_code <= cap_code;
                report_message <= ~powerup_restart;
            end
            halted <= (next_state != ST_RUN);
            ev_status <= (ev_status & ~ev_clr) | ev_set;
            if (wr && addr == A_ENABLE) begin
                ev_enable <= wdata[1:0];
            end
            irq <= |(((ev_status & ~ev_clr) | ev_set) & ev_enable);
            rdata <= wd_pc;
        end
    end

    // Read mux
    always_comb begin
        wd_pc = 32'h0000_0000;
        if (rd) begin
            case (addr)
                A_SAVED: wd_pc = saved_status_register;
                A_STATUS: wd_pc = {30'h0, ev_status};
                A_ENABLE: wd_pc = {30'h0, ev_enable};
                A_CTRL: wd_pc = {24'h0, 1'b0, halted, restart_code};
                default: wd_pc = 32'h0000_0000;
            endcase
        end
    end
endmodule : halt_reason_encoder

// [inc/halt_reason_pkg.sv]
package halt_reason_pkg;

    localparam int CODE_W = 6;
    localparam int NUM_SRC = 19;
    localparam int SAVED_CODE_LSB = 8;
    localparam int SAVED_CODE_MSB = 13;
    localparam int MODE_LSB = 24;
    localparam int MODE_MSB = 26;
    localparam int IS_FLAG_BIT = 26;
    localparam logic [7:0] SAVED_IPR_NUM = 8'h2B;

    localparam logic [5:0] C_NONE = 6'h00;
    localparam logic [5:0] C_EXT = 6'h02;
    localparam logic [5:0] C_PWRUP = 6'h03;
    localparam logic [5:0] C_ISP = 6'h04;
    localparam logic [5:0] C_DBL = 6'h05;
    localparam logic [5:0] C_HLT = 6'h06;
    localparam logic [5:0] C_VEC3 = 6'h07;
    localparam logic [5:0] C_VEC2 = 6'h08;
    localparam logic [5:0] C_CHM_IS = 6'h0A;
    localparam logic [5:0] C_CHM_VEC = 6'h0B;
    localparam logic [5:0] C_VEC_RD = 6'h0C;
    localparam logic [5:0] C_MCHK_AV = 6'h10;
    localparam logic [5:0] C_KSP_AV = 6'h11;
    localparam logic [5:0] C_DBL2 = 6'h12;
    localparam logic [5:0] C_DBL3 = 6'h13;
    localparam logic [5:0] C_EXC5 = 6'h19;
    localparam logic [5:0] C_EXC6 = 6'h1A;
    localparam logic [5:0] C_EXC7 = 6'h1B;
    localparam logic [5:0] C_REI5 = 6'h1D;
    localparam logic [5:0] C_REI6 = 6'h1E;
    localparam logic [5:0] C_REI7 = 6'h1F;
    localparam logic [5:0] C_SELFTEST = 6'h3F;

    localparam logic [2:0] MODE_KERNEL = 3'h0;
    localparam logic [1:0] VEC_LOW_3 = 2'h3;
    localparam logic [1:0] VEC_LOW_2 = 2'h2;

    localparam logic [31:0] SAVED_RESET = 32'h0000_0000;

    typedef struct packed {
        logic console_break;
        logic bus_halt_line;
        logic aux_halt;
        logic aux_halt_enable;
    } ext_halt_t;

    typedef struct packed {
        logic exc_start;
        logic rei_start;
        logic [2:0] mode;
        logic vec_valid;
        logic [1:0] vec_low;
        logic chm_exec;
        logic chm_vec_bit0;
        logic vec_read_err;
        logic isp_push_fault;
        logic mchk;
        logic mchk_reporting;
        logic mchk_servicing;
        logic ksnv_servicing;
        logic access_fault;
        logic halt_inst;
        logic kernel_mode;
        logic selftest_fail;
    } cpu_events_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SAVE = 2'b01,
        ST_HALTED = 2'b11
    } halt_state_t;

endpackage : halt_reason_pkg

// [design/halt_priority.sv]
`timescale 1ns/10ps
module halt_priority
    import halt_reason_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic [N-1:0] req,
    input wire logic [N*CODE_W-1:0] codes,
    output logic [CODE_W-1:0] code,
    output logic any
);
    // Lowest index wins
    logic [CODE_W-1:0] pick [N:0];
    assign pick[N] = C_NONE;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pri
            assign pick[i] = req[i] ? codes[i*CODE_W +: CODE_W] : pick[i+1];
        end
    endgenerate
    assign code = pick[0];
    assign any = |req;
endmodule : halt_priority

// [testbench/halt_reason_chk.sv]
`timescale 1ns/10ps
module halt_reason_chk
    import halt_reason_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ext_halt_t ext_halt,
    input wire cpu_events_t events,
    input wire logic restart_done,
    input wire logic powerup_restart,
    input wire logic [7:0] addr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [31:0] saved_status_register,
    input wire logic [CODE_W-1:0] restart_code,
    input wire logic halted,
    input wire logic report_message
);
    wire run_ok = !halted && !powerup_restart;
    wire ext_any = ext_halt.console_break || ext_halt.bus_halt_line
        || (ext_halt.aux_halt && ext_halt.aux_halt_enable);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_code_field: assert property (saved_status_register[13:8] == restart_code)
        else $error("saved field differs from code");
    a_powerup_code: assert property (powerup_restart && !halted
        |=> restart_code == 6'h03 && !report_message && halted) else $error("bad power-up");
    a_selftest_code: assert property (run_ok && events.selftest_fail
        |=> restart_code == 6'h3F) else $error("bad self-test code");
    a_ext_code: assert property (run_ok && ext_any && events == '0
        |=> restart_code == 6'h02 && halted) else $error("bad external code");
    a_no_false: assert property (run_ok && !ext_any && events == '0
        |=> !halted) else $error("halt with no cause");
    a_code_hold: assert property (halted && !restart_done
        |=> halted && $stable(restart_code)) else $error("code moved while halted");
    a_resume_run: assert property (halted && restart_done |=> !halted)
        else $error("no resume");
    a_msg_flag: assert property ($rose(halted)
        |-> report_message == (restart_code != C_PWRUP)) else $error("bad message flag");
    a_ipr_read: assert property (rd && addr == 8'h2B
        |=> rdata == $past(saved_status_register)) else $error("bad saved read");
endmodule : halt_reason_chk

bind halt_reason_encoder halt_reason_chk i_halt_reason_chk (.ref_clk, .rst_n, .ext_halt,
    .events, .restart_done, .powerup_restart, .addr, .rd, .rdata, .saved_status_register,
    .restart_code, .halted, .report_message);

// [testbench/halt_console_model.sv]
`timescale 1ns/10ps
module halt_console_model (
    input wire logic ref_clk,
    input wire logic halted,
    input wire logic slow,
    output logic restart_done = 1'b0
);
    logic [1:0] wait_cnt = 2'h0;
    // Resume only after the code has settled
    always @(posedge ref_clk) begin
        wait_cnt <= (halted && !restart_done) ? wait_cnt + 2'h1 : 2'h0;
        restart_done <= halted && !restart_done && wait_cnt == (slow ? 2'h3 : 2'h0);
    end
endmodule : halt_console_model

// [testbench/halt_reason_encoder_tb.sv]
`timescale 1ns/10ps
module halt_reason_encoder_tb;
    import halt_reason_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    ext_halt_t ext_halt = '0;
    cpu_events_t events = '0;
    logic [31:0] status_word = '0;
    logic restart_done, powerup_restart = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, saved;
    logic [5:0] restart_code;
    logic halted, report_message, irq;
    int failures = 0, n_tests = 0, cyc = 0;
    logic [8:0] rows [30] = '{9'h03F, 9'h012, 9'h013, 9'h005, 9'h010,
        9'h011, 9'h00C, 9'h007, 9'h008, 9'h10A, 9'h00B, 9'h004,
        9'h159, 9'h19A, 9'h1DB, 9'h15D, 9'h19E, 9'h1DF,
        9'h006, 9'h002, 9'h002, 9'h002, 9'h003, 9'h000,
        9'h000, 9'h03F, 9'h006, 9'h100, 9'h0C0, 9'h003};
    halt_console_model i_halt_console_model (.ref_clk, .halted, .slow, .restart_done);
    halt_reason_encoder i_halt_reason_encoder (.ref_clk, .rst_n, .ext_halt, .events,
        .status_word, .restart_done, .powerup_restart, .addr, .wdata, .wr, .rd, .rdata,
        .saved_status_register(saved), .restart_code, .halted, .report_message, .irq);
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask : bus
    task automatic hit(int k, logic [2:0] m);
        cpu_events_t e;
        ext_halt_t x;
        e = '0;
        x = '0;
        e.mode = m;
        case (k)
            0, 29: e.selftest_fail = 1'b1;
            1: {e.mchk, e.mchk_servicing} = 2'h3;
            2: {e.mchk, e.ksnv_servicing} = 2'h3;
            3: {e.mchk, e.mchk_reporting} = 2'h3;
            4: {e.access_fault, e.mchk_servicing} = 2'h3;
            5: {e.access_fault, e.ksnv_servicing} = 2'h3;
            6: e.vec_read_err = 1'b1;
            7: {e.vec_valid, e.vec_low} = 3'h7;
            8: {e.vec_valid, e.vec_low} = 3'h6;
            9: e.chm_exec = 1'b1;
            10: {e.chm_exec, e.chm_vec_bit0} = 2'h3;
            11: {e.exc_start, e.isp_push_fault} = 2'h3;
            12, 13, 14, 27: e.exc_start = 1'b1;
            15, 16, 17, 28: e.rei_start = 1'b1;
            18: {e.halt_inst, e.kernel_mode} = 2'h3;
            19: x.console_break = 1'b1;
            20: x.bus_halt_line = 1'b1;
            21: {x.aux_halt, x.aux_halt_enable} = 2'h3;
            23: x.aux_halt = 1'b1;
            24: e.halt_inst = 1'b1;
            25: {e.selftest_fail, x.bus_halt_line} = 2'h3;
            26: {e.halt_inst, e.kernel_mode, x.console_break} = 3'h7;
            default: ;
        endcase
        @(posedge ref_clk);
        events <= e;
        ext_halt <= x;
        powerup_restart <= (k == 22 || k == 29);
        status_word <= {5'h00, m, 24'h00_0000};
        @(posedge ref_clk);
        events <= '0;
        ext_halt <= '0;
        powerup_restart <= 1'b0;
        #1;
    endtask : hit
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk("reset code", restart_code, 32'h0);
        chk("reset halted", halted, 32'h0);
        bus(1'b1, 8'h08, 32'h3);
        for (int i = 0; i < 30; i++) begin
            hit(i, rows[i][8:6]);
            chk("halted", halted, rows[i][5:0] != 6'h00);
            if (rows[i][5:0] != 6'h00) begin
                chk("code", restart_code, rows[i][5:0]);
                chk("field", saved[13:8], rows[i][5:0]);
                chk("message", report_message, rows[i][5:0] != 6'h03);
            end
            for (int j = 0; j < 20 && halted === 1'b1; j++) @(posedge ref_clk);
            $display("row %0d done", i);
        end
        slow <= 1'b1;
        hit(20, 3'h0);
        hit(0, 3'h0);
        chk("held code", restart_code, 32'h02);
        chk("held halted", halted, 32'h1);
        slow <= 1'b0;
        bus(1'b0, 8'h00, 32'h0);
        chk("status", rdata, 32'h3);
        chk("irq", irq, 32'h1);
        bus(1'b1, 8'h04, 32'h3);
        @(posedge ref_clk);
        #1;
        chk("irq cleared", irq, 32'h0);
        bus(1'b1, 8'h08, 32'h0);
        hit(19, 3'h0);
        @(posedge ref_clk);
        #1;
        chk("irq masked", irq, 32'h0);
        bus(1'b0, 8'h2B, 32'h0);
        chk("saved read", rdata[13:8], 32'h02);
        bus(1'b0, 8'hFC, 32'h0);
        chk("unmapped", rdata, 32'h0);
        $display("hand tests done");
        test_done();
    end
endmodule : halt_reason_encoder_tb
